// ### rtl/fcs_host.sv
`timescale 1ns/10ps
// Function
// - Host raises programming supply and waits before any bus cycle.
// - Identifier read writes code then reads identifier at chosen location.
// - Program writes set-up code then target location and value.
// - Chip erase writes erase set-up code twice.
// - Two abort code writes cancel staged or failed operations.
module fcs_host #(
  parameter longint POLL_LIMIT = fcs_pkg::POLL_TMO_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // User command port.
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_fail,
  // Device programming pins.
  output logic [15:0] fl_addr,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [7:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic fl_vpp_en
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_VPP, ST_SET, ST_STB, ST_REC, ST_CHK, ST_OFF
  } fcs_state_e;
  ////////////////////////////////////////////////////////////////////////////

  // Kind of bus cycle for a given operation and step.
  function automatic logic [1:0] seq_kind(input logic [2:0] op,
                                          input logic [1:0] step);
    logic [1:0] k;
    k = fcs_pkg::K_END;
    case (op)
      fcs_pkg::OP_READ: if (step == 2'h0) k = fcs_pkg::K_RD;
      fcs_pkg::OP_ID: begin
        if (step == 2'h0) k = fcs_pkg::K_WR;
        else if (step == 2'h1) k = fcs_pkg::K_RD;
      end
      fcs_pkg::OP_PROG, fcs_pkg::OP_ERASE: begin
        if (step != 2'h2) k = fcs_pkg::K_WR;
        else k = fcs_pkg::K_POLL;
      end
      fcs_pkg::OP_ABORT: if (step != 2'h2) k = fcs_pkg::K_WR;
      default: k = fcs_pkg::K_END;
    endcase
    return k;
  endfunction : seq_kind
  // Byte written at a given step; the first step is always a command code.
  function automatic logic [7:0] seq_wdata(input logic [2:0] op,
                                           input logic [1:0] step,
                                           input logic [7:0] dat);
    logic [7:0] d;
    case (op)
      fcs_pkg::OP_ID: d = fcs_pkg::CODE_ID;
      fcs_pkg::OP_PROG: d = (step == 2'h0) ? fcs_pkg::CODE_PROG : dat;
      fcs_pkg::OP_ERASE: d = fcs_pkg::CODE_ERASE;
      default: d = fcs_pkg::CODE_ABORT;
    endcase
    return d;
  endfunction : seq_wdata
  ////////////////////////////////////////////////////////////////////////////

  fcs_state_e st_ff, nxt_st;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [1:0] step_ff, nxt_step;
  logic [2:0] op_ff, nxt_op;
  logic [15:0] addr_ff, nxt_addr;
  logic [7:0] data_ff, nxt_data;
  logic [63:0] tmo_ff, nxt_tmo;
  logic prev_tog_ff, nxt_prev_tog;
  logic have_prev_ff, nxt_have_prev;
  logic fail_ff, nxt_fail;
  logic [7:0] rd_ff, nxt_rd;
  logic [7:0] dq_s1_ff, dq_s2_ff;
  logic ready_ff, nxt_ready;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic [15:0] fl_addr_ff, nxt_fl_addr;
  logic [7:0] fl_dq_o_ff, nxt_fl_dq_o;
  logic fl_dq_oe_ff, nxt_fl_dq_oe;
  logic fl_ce_n_ff, nxt_fl_ce_n;
  logic fl_oe_n_ff, nxt_fl_oe_n;
  logic fl_we_n_ff, nxt_fl_we_n;
  logic fl_vpp_ff, nxt_fl_vpp;
  logic [1:0] kind;
  logic tog_now;
  logic poll_ok;

  assign kind = seq_kind(op_ff, step_ff);
  assign tog_now = rd_ff[fcs_pkg::TOGGLE_STATUS_BIT];
  // Polling bit shows the true written value after a program and one after
  // an erase; while busy it differs, so it cannot end the wait early.
  assign poll_ok = (op_ff == fcs_pkg::OP_ERASE) ?
    rd_ff[fcs_pkg::POLLING_STATUS_BIT] :
    (rd_ff[fcs_pkg::POLLING_STATUS_BIT] ==
     data_ff[fcs_pkg::POLLING_STATUS_BIT]);
  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_step = step_ff;
    nxt_op = op_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_tmo = tmo_ff;
    nxt_prev_tog = prev_tog_ff;
    nxt_have_prev = have_prev_ff;
    nxt_fail = fail_ff;
    nxt_rd = rd_ff;
    nxt_ready = ready_ff;
    nxt_rsp_valid = 1'b0;
    nxt_fl_addr = fl_addr_ff;
    nxt_fl_dq_o = fl_dq_o_ff;
    nxt_fl_dq_oe = fl_dq_oe_ff;
    nxt_fl_ce_n = fl_ce_n_ff;
    nxt_fl_oe_n = fl_oe_n_ff;
    nxt_fl_we_n = fl_we_n_ff;
    nxt_fl_vpp = fl_vpp_ff;
    if (cnt_ff != 8'h00) nxt_cnt = cnt_ff - 8'h01;
    if (kind == fcs_pkg::K_POLL && st_ff != ST_IDLE) begin
      nxt_tmo = tmo_ff + 64'h1;
    end
    case (st_ff)
      ST_IDLE: begin
        if (cmd_valid && ready_ff) begin
          nxt_ready = 1'b0;
          nxt_op = cmd_op;
          nxt_addr = cmd_addr;
          nxt_data = cmd_data;
          nxt_step = 2'h0;
          nxt_fail = 1'b0;
          nxt_tmo = 64'h0;
          nxt_have_prev = 1'b0;
          nxt_fl_vpp = 1'b1;
          nxt_cnt = fcs_pkg::VPP_CYC;
          nxt_st = ST_VPP;
        end
      end
      ST_VPP: if (cnt_ff == 8'h00) nxt_st = ST_SET;
      ST_SET: begin
        // Address and data settle before either strobe falls.
        nxt_fl_addr = addr_ff;
        nxt_fl_ce_n = 1'b0;
        nxt_fl_dq_oe = (kind == fcs_pkg::K_WR);
        nxt_fl_dq_o = seq_wdata(op_ff, step_ff, data_ff);
        nxt_cnt = fcs_pkg::AS_CYC;
        nxt_st = ST_STB;
      end
      ST_STB: begin
        if (cnt_ff == 8'h00 && fl_we_n_ff && fl_oe_n_ff) begin
          if (kind == fcs_pkg::K_WR) begin
            nxt_fl_we_n = 1'b0;
            nxt_cnt = fcs_pkg::WP_CYC;
          end else begin
            nxt_fl_oe_n = 1'b0;
            nxt_cnt = fcs_pkg::RD_CYC;
          end
        end else if (cnt_ff == 8'h00) begin
          // Both strobes rise together; data stays driven through recovery.
          nxt_rd = dq_s2_ff;
          nxt_fl_we_n = 1'b1;
          nxt_fl_oe_n = 1'b1;
          nxt_fl_ce_n = 1'b1;
          nxt_cnt = fcs_pkg::REC_CYC;
          nxt_st = ST_REC;
        end
      end
      ST_REC: begin
        if (cnt_ff == 8'h00) begin
          nxt_fl_dq_oe = 1'b0;
          if (kind == fcs_pkg::K_POLL) begin
            nxt_st = ST_CHK;
          end else begin
            nxt_step = step_ff + 2'h1;
            nxt_st = (seq_kind(op_ff, step_ff + 2'h1) == fcs_pkg::K_END) ?
              ST_OFF : ST_SET;
          end
        end
      end
      ST_CHK: begin
        nxt_prev_tog = tog_now;
        nxt_have_prev = 1'b1;
        if (have_prev_ff && prev_tog_ff == tog_now && poll_ok) begin
          nxt_st = ST_OFF;
        end else if (tmo_ff >= 64'(POLL_LIMIT)) begin
          // A stuck algorithm is cleared by the abort pair.
          nxt_fail = 1'b1;
          nxt_op = fcs_pkg::OP_ABORT;
          nxt_step = 2'h0;
          nxt_st = ST_SET;
        end else begin
          nxt_st = ST_SET;
        end
      end
      ST_OFF: begin
        // Dropping the supply returns the command register to default.
        nxt_fl_vpp = 1'b0;
        nxt_rsp_valid = 1'b1;
        nxt_ready = 1'b1;
        nxt_st = ST_IDLE;
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    dq_s1_ff <= fl_dq_i;
    dq_s2_ff <= dq_s1_ff;
    if (sys_rst) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      step_ff <= 2'h0;
      op_ff <= fcs_pkg::OP_READ;
      addr_ff <= 16'h0000;
      data_ff <= 8'h00;
      tmo_ff <= 64'h0;
      prev_tog_ff <= 1'b0;
      have_prev_ff <= 1'b0;
      fail_ff <= 1'b0;
      rd_ff <= 8'h00;
      ready_ff <= 1'b1;
      rsp_valid_ff <= 1'b0;
      fl_addr_ff <= 16'h0000;
      fl_dq_o_ff <= 8'h00;
      fl_dq_oe_ff <= 1'b0;
      fl_ce_n_ff <= 1'b1;
      fl_oe_n_ff <= 1'b1;
      fl_we_n_ff <= 1'b1;
      fl_vpp_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      step_ff <= nxt_step;
      op_ff <= nxt_op;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      tmo_ff <= nxt_tmo;
      prev_tog_ff <= nxt_prev_tog;
      have_prev_ff <= nxt_have_prev;
      fail_ff <= nxt_fail;
      rd_ff <= nxt_rd;
      ready_ff <= nxt_ready;
      rsp_valid_ff <= nxt_rsp_valid;
      fl_addr_ff <= nxt_fl_addr;
      fl_dq_o_ff <= nxt_fl_dq_o;
      fl_dq_oe_ff <= nxt_fl_dq_oe;
      fl_ce_n_ff <= nxt_fl_ce_n;
      fl_oe_n_ff <= nxt_fl_oe_n;
      fl_we_n_ff <= nxt_fl_we_n;
      fl_vpp_ff <= nxt_fl_vpp;
    end
  end
  ////////////////////////////////////////////////////////////////////////////

  assign cmd_ready = ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rd_ff;
  assign rsp_fail = fail_ff;
  assign fl_addr = fl_addr_ff;
  assign fl_dq_o = fl_dq_o_ff;
  assign fl_dq_oe = fl_dq_oe_ff;
  assign fl_ce_n = fl_ce_n_ff;
  assign fl_oe_n = fl_oe_n_ff;
  assign fl_we_n = fl_we_n_ff;
  assign fl_vpp_en = fl_vpp_ff;
endmodule : fcs_host

// ### rtl/fcs_pkg.sv
package fcs_pkg;

  // Host operation codes presented on cmd_op.
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_ID = 3'h1;
  localparam logic [2:0] OP_PROG = 3'h2;
  localparam logic [2:0] OP_ERASE = 3'h3;
  localparam logic [2:0] OP_ABORT = 3'h4;

  // Command codes written into the device command register.
  localparam logic [7:0] CODE_ID = 8'h90;
  localparam logic [7:0] CODE_ERASE = 8'h30;
  localparam logic [7:0] CODE_PROG = 8'h40;
  localparam logic [7:0] CODE_ABORT = 8'hff;

  // Status bit positions on the data lines.
  localparam int TOGGLE_STATUS_BIT = 6;
  localparam int POLLING_STATUS_BIT = 7;

  // Kind of bus cycle at one step of a sequence.
  localparam logic [1:0] K_WR = 2'h0;
  localparam logic [1:0] K_RD = 2'h1;
  localparam logic [1:0] K_POLL = 2'h2;
  localparam logic [1:0] K_END = 2'h3;

  // Clock rate and bus timing.
  localparam int CLK_MHZ = 20;
  localparam int T_VPP_NS = 2000;
  localparam int T_AS_NS = 50;
  localparam int T_WP_NS = 100;
  localparam int T_ACC_NS = 150;
  localparam int T_REC_NS = 100;
  localparam int SYNC_STAGES = 2;
  localparam int POLL_TMO_MS = 10000;

  localparam logic [7:0] VPP_CYC = 8'((T_VPP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] AS_CYC = 8'((T_AS_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RD_CYC =
    8'((T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES);
  localparam logic [7:0] REC_CYC = 8'((T_REC_NS * CLK_MHZ + 999) / 1000);
  localparam longint POLL_TMO_CYC = longint'(POLL_TMO_MS) * CLK_MHZ * 1000;

endpackage : fcs_pkg

// ### bench/fcs_host_assertions.sv
`timescale 1ns/10ps
module fcs_host_chk (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // User port.
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  // Device pins.
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_dq_o,
  input wire logic fl_dq_oe,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic fl_vpp_en
);
  logic [5:0] vcnt_ff;
  logic [5:0] nxt_vcnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Counts cycles since the programming supply was raised.
  always_comb begin
    nxt_vcnt = vcnt_ff;
    if (!fl_vpp_en) begin
      nxt_vcnt = 6'h0;
    end else if (vcnt_ff != 6'h3f) begin
      nxt_vcnt = vcnt_ff + 6'h1;
    end
  end
  always_ff @(posedge mclk) begin
    vcnt_ff <= sys_rst ? 6'h0 : nxt_vcnt;
  end
  AST_WR_QUAL: assert property (
    !fl_we_n |-> !fl_ce_n && fl_oe_n)
    else $error("write strobe without chip select");
  AST_RD_QUAL: assert property (
    !fl_oe_n |-> !fl_ce_n && fl_we_n && !fl_dq_oe)
    else $error("bad read cycle");
  AST_VPP_UP: assert property (
    !fl_ce_n |-> fl_vpp_en && vcnt_ff >= 6'h27)
    else $error("bus cycle without settled supply");
  AST_ADDR_HOLD: assert property (
    !fl_we_n |-> $stable(fl_addr))
    else $error("address moved during write");
  AST_DATA_HOLD: assert property (
    $rose(fl_we_n) |-> $stable(fl_dq_o) && fl_dq_oe)
    else $error("data moved at write end");
  AST_WE_WIDTH: assert property (
    $fell(fl_we_n) |-> !fl_we_n[*3] ##1 fl_we_n)
    else $error("write strobe width wrong");
  AST_RSP_PULSE: assert property (
    rsp_valid |-> cmd_ready ##1 !rsp_valid)
    else $error("response not a single pulse");
  AST_TAKE: assert property (
    cmd_valid && cmd_ready |=> !cmd_ready && fl_vpp_en)
    else $error("request not taken");
endmodule : fcs_host_chk
bind fcs_host fcs_host_chk u_chk (.mclk, .sys_rst, .cmd_valid, .cmd_ready,
  .rsp_valid, .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n,
  .fl_vpp_en);

// ### bench/fcs_dev_model.sv
`timescale 1ns/10ps
module fcs_dev #(
  // Identity values are arbitrary.
  parameter logic [7:0] MFR = 8'ha5,
  parameter logic [7:0] DEV = 8'h3c
) (
  // Pins.
  input wire logic mclk,
  input wire logic vpp,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] a,
  input wire logic [7:0] d,
  input wire logic [31:0] busy_len,
  output logic [7:0] q
);
  logic [7:0] mem [0:65535];
  logic [7:0] stg = 8'h0;
  logic [7:0] wd = 8'h0;
  logic [7:0] rd;
  logic [15:0] la = 16'h0;
  logic [15:0] pa = 16'h0;
  logic id = 1'b0;
  logic er = 1'b0;
  logic tog = 1'b0;
  int busy = 0;
  wire wr = !ce_n && !we_n;
  initial foreach (mem[i]) mem[i] = 8'hff;
  always @(negedge vpp) begin
    stg = 8'h0;
    id = 1'b0;
  end
  always @(posedge wr) la = a;
  // An unknown supply level at power-up counts as low, so the first strobe
  // edges out of reset cannot stage a bogus command.
  always @(negedge wr) begin
    if (vpp !== 1'b1) begin
      stg = 8'h0;
    end else if (busy > 0) begin
      if (d == 8'hff && stg == 8'hff) busy = 0;
      stg = d;
    end else begin
      id = 1'b0;
      case (stg)
        8'h30: if (d == 8'h30) begin
          er = 1'b1;
          busy = busy_len;
          foreach (mem[i]) mem[i] = 8'hff;
        end
        8'h40: begin
          er = 1'b0;
          pa = la;
          wd = d;
          busy = busy_len;
        end
        default: id = (d == 8'h90);
      endcase
      stg = (stg == 8'h0 || stg == 8'hff) ? d : 8'h0;
    end
  end
  always @(posedge mclk) if (busy > 0) begin
    busy = busy - 1;
    if (busy == 0 && !er) mem[pa] = wd;
  end
  // Toggle as each read opens, while chip select is surely low; chip select
  // and output strobe rise together at the end of a read.
  always @(negedge oe_n) if (ce_n === 1'b0 && busy > 0) tog = !tog;
  always_comb begin
    if (busy > 0) rd = {er ? 1'b0 : ~wd[7], tog, 6'h0};
    else if (id) rd = a[0] ? DEV : MFR;
    else rd = mem[a];
  end
  assign q = (!ce_n && !oe_n && we_n) ? rd : ~rd;
endmodule : fcs_dev

// ### bench/tb_flash_command_sequencer.sv
`timescale 1ns/10ps
module tb_flash_command_sequencer;
  logic mclk = 0, sys_rst = 1, cmd_valid = 0;
  logic [2:0] cmd_op = 3'h0;
  logic [15:0] cmd_addr = 16'h0, fl_addr;
  logic [7:0] cmd_data = 8'h0, rsp_data, fl_dq_o, q;
  logic cmd_ready, rsp_valid, rsp_fail, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
  logic fl_vpp_en;
  int busy_len = 50, n_fail = 0, samples_checked = 0;
  wire logic [7:0] fl_dq_i = fl_dq_oe ? fl_dq_o : q;
  always #25 mclk = ~mclk;
  fcs_host #(.POLL_LIMIT(2000)) DUT (.mclk, .sys_rst, .cmd_valid, .cmd_op,
    .cmd_addr, .cmd_data, .cmd_ready, .rsp_valid, .rsp_data, .rsp_fail,
    .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_dq_i, .fl_ce_n, .fl_oe_n, .fl_we_n,
    .fl_vpp_en);
  // Identity values are arbitrary.
  fcs_dev #(.MFR(8'h5c), .DEV(8'h61)) u_dev (.mclk, .vpp(fl_vpp_en),
    .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .a(fl_addr),
    .d(fl_dq_o), .busy_len, .q);
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (e !== g) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task run(input logic [2:0] op, input logic [15:0] ad, input logic [7:0] dt);
    int n;
    n = 0;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= ad;
    cmd_data <= dt;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 30000);
    chk("rsp_valid", 8'h1, {7'h0, rsp_valid});
  endtask : run
  task t_reset;
    chk("idle pins", 8'h7, {5'h0, cmd_ready, fl_ce_n, !fl_vpp_en});
    $display("reset test done");
  endtask : t_reset
  task t_erase;
    busy_len = 300;
    run(fcs_pkg::OP_ERASE, 16'h0, 8'h0);
    chk("erase status", 8'hff, rsp_data);
    run(fcs_pkg::OP_READ, 16'h1234, 8'h0);
    chk("erased byte", 8'hff, rsp_data);
    $display("erase test done");
  endtask : t_erase
  task t_prog;
    busy_len = 100;
    run(fcs_pkg::OP_PROG, 16'h1234, 8'h5a);
    chk("prog status", 8'h5a, rsp_data);
    run(fcs_pkg::OP_READ, 16'h1234, 8'h0);
    chk("programmed byte", 8'h5a, rsp_data);
    run(fcs_pkg::OP_READ, 16'h1235, 8'h0);
    chk("neighbour byte", 8'hff, rsp_data);
    $display("program test done");
  endtask : t_prog
  task t_id;
    run(fcs_pkg::OP_ID, 16'h0, 8'h0);
    chk("maker code", 8'h5c, rsp_data);
    run(fcs_pkg::OP_ID, 16'h1, 8'h0);
    chk("part code", 8'h61, rsp_data);
    $display("identifier test done");
  endtask : t_id
  task t_abort;
    busy_len = 100000;
    run(fcs_pkg::OP_PROG, 16'h0010, 8'h33);
    chk("fail flag", 8'h1, {7'h0, rsp_fail});
    busy_len = 50;
    run(fcs_pkg::OP_READ, 16'h0010, 8'h0);
    chk("aborted byte", 8'hff, rsp_data);
    run(fcs_pkg::OP_ABORT, 16'h0, 8'h0);
    chk("abort flag", 8'h0, {7'h0, rsp_fail});
    // An undefined operation code must still answer, without a failure.
    run(3'h5, 16'h0, 8'h0);
    chk("odd op flag", 8'h0, {7'h0, rsp_fail});
    $display("abort test done");
  endtask : t_abort
  initial begin
    repeat (80000) @(posedge mclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset();
    t_erase();
    t_prog();
    t_id();
    t_abort();
    end_of_test();
  end
endmodule : tb_flash_command_sequencer
